/* File: core/tce_axil_slave.v */
/*
 AXI4-Lite slave front end: captures one write (address and data in
 either order) and one read, and presents them as single-cycle strobes.
 Assumes the register file answers reads combinationally from its
 registers in the same cycle as the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module tce_axil_slave (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [7:0] s_awaddr,
	input wire s_awvalid,
	output reg s_awready,
	input wire [31:0] s_wdata,
	input wire [3:0] s_wstrb,
	input wire s_wvalid,
	output reg s_wready,
	output reg [1:0] s_bresp,
	output reg s_bvalid,
	input wire s_bready,
	input wire [7:0] s_araddr,
	input wire s_arvalid,
	output reg s_arready,
	output reg [31:0] s_rdata,
	output reg [1:0] s_rresp,
	output reg s_rvalid,
	input wire s_rready,
	output reg wr_stb,
	output reg [7:0] wr_addr,
	output reg [31:0] wr_data,
	output reg [3:0] wr_strb,
	output wire [7:0] rd_addr,
	output wire rd_stb,
	input wire [31:0] rd_data,
	input wire rd_ok,
	input wire wr_ok
);
	reg have_aw;
	reg have_w;
	reg [7:0] ar_hold;
	reg ar_pend;

	// Read strobe fires one cycle after the address is taken
	assign rd_addr = ar_hold;
	assign rd_stb = ar_pend;

	// Write channel: hold address and data until both arrived
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b1;
			s_wready <= 1'b1;
			have_aw <= 1'b0;
			have_w <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= 2'b00;
			wr_stb <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else if (ce) begin
			wr_stb <= 1'b0;
			if (s_awvalid && s_awready) begin
				wr_addr <= s_awaddr;
				have_aw <= 1'b1;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				wr_data <= s_wdata;
				wr_strb <= s_wstrb;
				have_w <= 1'b1;
				s_wready <= 1'b0;
			end
			if (have_aw && have_w && !s_bvalid && !wr_stb) begin
				wr_stb <= 1'b1;
			end
			// Response one cycle after the strobe, so wr_ok reflects the address
			if (wr_stb) begin
				s_bvalid <= 1'b1;
				s_bresp <= wr_ok ? 2'b00 : 2'b10;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
				have_aw <= 1'b0;
				have_w <= 1'b0;
				s_awready <= 1'b1;
				s_wready <= 1'b1;
			end
		end
	end

	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b1;
			ar_hold <= 8'h00;
			ar_pend <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= 2'b00;
		end else if (ce) begin
			ar_pend <= 1'b0;
			if (s_arvalid && s_arready) begin
				ar_hold <= s_araddr;
				ar_pend <= 1'b1;
				s_arready <= 1'b0;
			end
			if (ar_pend) begin
				s_rvalid <= 1'b1;
				s_rdata <= rd_ok ? rd_data : 32'h0000_0000;
				s_rresp <= rd_ok ? 2'b00 : 2'b10;
			end
			if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
				s_arready <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: core/tce_code_map.v */
/*
 Completion code selector: turns one cycle's graduation event into a
 completion code. Registered output, one cycle of latency.
 Assumes the pipeline raises at most the event flags that describe
 one graduation slot per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tce_defines.vh"
module tce_code_map (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire ext_en,
	input wire grad_valid,
	input wire grad_load,
	input wire grad_store,
	input wire grad_branch,
	input wire grad_unpredictable,
	input wire grad_sync,
	input wire [3:0] stall_cause,
	output reg [3:0] code
);
	reg [3:0] next_code;

	// Priority: completions first, then stall causes in fixed order
	always @* begin
		next_code = `TCE_NO_COMPLETION;
		if (grad_valid) begin
			if (grad_branch && grad_unpredictable) begin
				if (grad_load) begin
					next_code = `TCE_BRANCHED_LOAD;
				end else if (grad_store) begin
					next_code = `TCE_BRANCHED_STORE;
				end else begin
					next_code = `TCE_BRANCHED_COMPLETION;
				end
			end else if (grad_load) begin
				next_code = `TCE_LOAD_COMPLETED;
			end else if (grad_store) begin
				next_code = `TCE_STORE_COMPLETED;
			end else if (grad_sync) begin
				// Sync waits for a plain instruction
				next_code = `TCE_PC_SYNC_MARKER;
			end else begin
				next_code = `TCE_SEQ_COMPLETION;
			end
		end else if (ext_en) begin
			// Stall codes only under the extension
			if (stall_cause[`TCE_CAUSE_MISS]) begin
				next_code = `TCE_STALL_MEM_MISS;
			end else if (stall_cause[`TCE_CAUSE_MISPRED]) begin
				next_code = `TCE_STALL_MISPREDICT;
			end else if (stall_cause[`TCE_CAUSE_REPLAY]) begin
				next_code = `TCE_STALL_REPLAY;
			end else if (stall_cause[`TCE_CAUSE_BACKP]) begin
				next_code = `TCE_STALL_BACKPRESSURE;
			end
		end
	end

	// No path above yields 1100..1111
	always @(posedge aclk) begin
		if (!aresetn) begin
			code <= `TCE_NO_COMPLETION;
		end else if (ce) begin
			code <= next_code;
		end
	end
endmodule
`default_nettype wire

/* File: core/tce_defines.vh */
/*
 Constants for the trace completion encoder: register offsets, field
 positions, completion codes and reset values.
 Assumes inclusion by bare name from the core files.
*/
`ifndef TCE_DEFINES_VH
`define TCE_DEFINES_VH
// Overview of operation
// - Extended stall codes are produced only while the extension enable bit 28 of the active trace control word is one.
// - With the extension on, the completion field is four bits wide, one wider than standard.
// - An idle cycle caused by a load or store cache miss carries code 1000.
// - An idle cycle caused by a branch or return mispredict carries code 1001.
// - An idle cycle caused by an instruction replay carries code 1010.
// - A graduation stall on backpressure carries code 1011.
// - Codes 1100 to 1111 are never produced.
// - Code 0000 is produced when nothing completed, by stall or by a killed instruction.
// - A sequential load completion carries 0010 and a sequential store 0011.
// - Code 0100 marks a periodic PC sync and is never put on an unpredictable branch, load or store.
// - Codes 0101, 0110 and 0111 mark an unpredictable branch that is plain, a load or a store.
// - The expanded format two word has the code in bits 5 to 2 and marker 10 in bits 1 to 0.
// - On request, format two carries the fetch miss flag at bit 7 and the call tag at bit 6.
// - The expanded format three word is 28 bits for a 16-bit payload and 44 bits for 32.
// - Format three holds payload from bit 12, kind flag 11, last beat 10, class 9..7, code 6..3, zeros 2..0.
// - Format three carries the optional bits only on request and reports their presence.

// Register byte offsets
`define TCE_REG_SW_CTRL 32'h0000_0000
`define TCE_REG_PROBE_CTRL 32'h0000_0004
`define TCE_REG_SEL 32'h0000_0008
`define TCE_REG_STATUS 32'h0000_000C
`define TCE_REG_LAST_LO 32'h0000_0010
`define TCE_REG_LAST_HI 32'h0000_0014
`define TCE_REG_COUNT 32'h0000_0018
// Field positions
`define TCE_EXT_BIT 28
`define TCE_WIDE_SEL_BIT 23
`define TCE_OPT_BIT 0
`define TCE_SEL_PROBE_BIT 0
// Reset values
`define TCE_CTRL_RST 32'h0000_0000
`define TCE_SEL_RST 1'b0
// Completion codes
`define TCE_NO_COMPLETION 4'h0
`define TCE_SEQ_COMPLETION 4'h1
`define TCE_LOAD_COMPLETED 4'h2
`define TCE_STORE_COMPLETED 4'h3
`define TCE_PC_SYNC_MARKER 4'h4
`define TCE_BRANCHED_COMPLETION 4'h5
`define TCE_BRANCHED_LOAD 4'h6
`define TCE_BRANCHED_STORE 4'h7
`define TCE_STALL_MEM_MISS 4'h8
`define TCE_STALL_MISPREDICT 4'h9
`define TCE_STALL_REPLAY 4'hA
`define TCE_STALL_BACKPRESSURE 4'hB
// Format markers and widths
`define TCE_F2_MARKER 2'b10
`define TCE_F3_NARROW_W 28
`define TCE_F3_WIDE_W 44
// Stall cause indices
`define TCE_CAUSE_MISS 0
`define TCE_CAUSE_MISPRED 1
`define TCE_CAUSE_REPLAY 2
`define TCE_CAUSE_BACKP 3
`endif

/* File: core/tce_encoder.v */
/*
 Trace completion encoder top: AXI4-Lite control registers, completion
 code mapping and assembly of format two and format three words.
 Assumes the pipeline presents graduation events and data beats
 synchronous to aclk, and that the trace collector samples the word
 outputs whenever their valid flag is high (no back-pressure).
*/
`timescale 1ns/1ps
`default_nettype none
`include "tce_defines.vh"
module tce_encoder #(
	parameter PAYLOAD_MAX_W = 32
) (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [7:0] s_awaddr,
	input wire s_awvalid,
	output wire s_awready,
	input wire [31:0] s_wdata,
	input wire [3:0] s_wstrb,
	input wire s_wvalid,
	output wire s_wready,
	output wire [1:0] s_bresp,
	output wire s_bvalid,
	input wire s_bready,
	input wire [7:0] s_araddr,
	input wire s_arvalid,
	output wire s_arready,
	output wire [31:0] s_rdata,
	output wire [1:0] s_rresp,
	output wire s_rvalid,
	input wire s_rready,
	input wire grad_valid,
	input wire grad_load,
	input wire grad_store,
	input wire grad_branch,
	input wire grad_unpredictable,
	input wire grad_sync,
	input wire [3:0] stall_cause,
	input wire fetch_miss_flag,
	input wire call_tag,
	input wire beat_valid,
	input wire [PAYLOAD_MAX_W-1:0] beat_payload,
	input wire value_kind_flag,
	input wire last_beat_flag,
	input wire [2:0] packet_class,
	output reg format_two_valid,
	output reg [7:0] format_two_word,
	output reg [3:0] format_two_len,
	output reg format_three_valid,
	output reg [47:0] format_three_word,
	output reg [5:0] format_three_len,
	output reg opt_bits_present
);
	// Control registers
	reg [31:0] sw_trace_control;
	reg [31:0] probe_trace_control;
	reg probe_owns;
	reg [31:0] word_count;

	wire wr_stb;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [7:0] rd_addr;
	wire rd_stb;
	reg [31:0] rd_data;
	reg rd_ok;
	reg wr_ok;

	// Active control word picked by which side owns trace
	wire [31:0] active_ctrl = probe_owns ? probe_trace_control : sw_trace_control;
	wire ext_en = active_ctrl[`TCE_EXT_BIT];
	wire wide_payload_sel = probe_trace_control[`TCE_WIDE_SEL_BIT];
	wire opt_en = active_ctrl[`TCE_OPT_BIT];

	// Pipeline delay registers to align with the registered code
	reg d_fetch_miss;
	reg d_call_tag;
	reg d_beat_valid;
	reg [PAYLOAD_MAX_W-1:0] d_payload;
	reg d_kind;
	reg d_last;
	reg [2:0] d_class;
	reg d_ext;
	reg d_opt;
	reg d_wide;
	wire [3:0] completion_code;

	// Merge a written word into a register under byte strobes
	function [31:0] tce_merge;
		input [31:0] old;
		input [31:0] val;
		input [3:0] strb;
		integer i;
		begin
			tce_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					tce_merge[i*8 +: 8] = val[i*8 +: 8];
				end
			end
		end
	endfunction

	// Known-address check shared by reads and writes
	function tce_mapped;
		input [7:0] a;
		begin
			tce_mapped = (a == `TCE_REG_SW_CTRL) ||
				(a == `TCE_REG_PROBE_CTRL) ||
				(a == `TCE_REG_SEL) ||
				(a == `TCE_REG_STATUS) ||
				(a == `TCE_REG_LAST_LO) ||
				(a == `TCE_REG_LAST_HI) ||
				(a == `TCE_REG_COUNT);
		end
	endfunction

	tce_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_addr(rd_addr),
		.rd_stb(rd_stb),
		.rd_data(rd_data),
		.rd_ok(rd_ok),
		.wr_ok(wr_ok)
	);

	tce_code_map u_map (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.ext_en(ext_en),
		.grad_valid(grad_valid),
		.grad_load(grad_load),
		.grad_store(grad_store),
		.grad_branch(grad_branch),
		.grad_unpredictable(grad_unpredictable),
		.grad_sync(grad_sync),
		.stall_cause(stall_cause),
		.code(completion_code)
	);

	// Register writes; read-only registers ignore writes but answer OKAY
	always @(posedge aclk) begin
		if (!aresetn) begin
			sw_trace_control <= `TCE_CTRL_RST;
			probe_trace_control <= `TCE_CTRL_RST;
			probe_owns <= `TCE_SEL_RST;
		end else if (ce && wr_stb) begin
			if (wr_addr == `TCE_REG_SW_CTRL) begin
				sw_trace_control <= tce_merge(sw_trace_control, wr_data, wr_strb);
			end
			if (wr_addr == `TCE_REG_PROBE_CTRL) begin
				probe_trace_control <= tce_merge(probe_trace_control, wr_data, wr_strb);
			end
			if (wr_addr == `TCE_REG_SEL && wr_strb[0]) begin
				probe_owns <= wr_data[`TCE_SEL_PROBE_BIT];
			end
		end
	end

	// Read mux; unmapped addresses give SLVERR and zero data
	always @* begin
		rd_ok = tce_mapped(rd_addr);
		wr_ok = tce_mapped(wr_addr);
		case (rd_addr)
			`TCE_REG_SW_CTRL: rd_data = sw_trace_control;
			`TCE_REG_PROBE_CTRL: rd_data = probe_trace_control;
			`TCE_REG_SEL: rd_data = {31'h0000_0000, probe_owns};
			`TCE_REG_STATUS: rd_data = {24'h00_0000, completion_code,
				1'b0, opt_en, wide_payload_sel, ext_en};
			`TCE_REG_LAST_LO: rd_data = format_three_word[31:0];
			`TCE_REG_LAST_HI: rd_data = {16'h0000, format_three_word[47:32]};
			`TCE_REG_COUNT: rd_data = word_count;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// Align side information with the code register's one-cycle latency
	always @(posedge aclk) begin
		if (!aresetn) begin
			d_fetch_miss <= 1'b0;
			d_call_tag <= 1'b0;
			d_beat_valid <= 1'b0;
			d_payload <= {PAYLOAD_MAX_W{1'b0}};
			d_kind <= 1'b0;
			d_last <= 1'b0;
			d_class <= 3'h0;
			d_ext <= 1'b0;
			d_opt <= 1'b0;
			d_wide <= 1'b0;
		end else if (ce) begin
			d_fetch_miss <= fetch_miss_flag;
			d_call_tag <= call_tag;
			d_beat_valid <= beat_valid;
			d_payload <= beat_payload;
			d_kind <= value_kind_flag;
			d_last <= last_beat_flag;
			d_class <= packet_class;
			d_ext <= ext_en;
			d_opt <= opt_en;
			d_wide <= wide_payload_sel;
		end
	end

	// Format two: one word every cycle; standard form drops the top code bit
	always @(posedge aclk) begin
		if (!aresetn) begin
			format_two_valid <= 1'b0;
			format_two_word <= 8'h00;
			format_two_len <= 4'h0;
		end else if (ce) begin
			format_two_valid <= 1'b1;
			if (d_ext) begin
				// Code in 5..2, marker in 1..0
				format_two_word <= {d_opt & d_fetch_miss,
					d_opt & d_call_tag,
					completion_code,
					`TCE_F2_MARKER};
				if (d_opt) begin
					format_two_len <= 4'h8;
				end else begin
					format_two_len <= 4'h6;
				end
			end else begin
				// Three-bit code, optional bits shift down one place
				format_two_word <= {1'b0,
					d_opt & d_fetch_miss,
					d_opt & d_call_tag,
					completion_code[2:0],
					`TCE_F2_MARKER};
				if (d_opt) begin
					format_two_len <= 4'h7;
				end else begin
					format_two_len <= 4'h5;
				end
			end
		end
	end

	// Format three: one word per data beat; unused high bits are zero
	always @(posedge aclk) begin
		if (!aresetn) begin
			format_three_valid <= 1'b0;
			format_three_word <= 48'h0000_0000_0000;
			format_three_len <= 6'h00;
			opt_bits_present <= 1'b0;
			word_count <= 32'h0000_0000;
		end else if (ce) begin
			format_three_valid <= d_beat_valid;
			opt_bits_present <= d_opt;
			if (d_beat_valid) begin
				word_count <= word_count + 32'h0000_0001;
				if (d_ext && d_wide) begin
					// 44 bits, payload 43..12
					format_three_word <= {2'b00,
						d_opt & d_fetch_miss,
						d_opt & d_call_tag,
						d_payload[31:0],
						d_kind,
						d_last,
						d_class,
						completion_code,
						3'b000};
					if (d_opt) begin
						format_three_len <= 6'd46;
					end else begin
						format_three_len <= 6'd44;
					end
				end else if (d_ext) begin
					// 28 bits, payload 27..12
					format_three_word <= {18'h0_0000,
						d_opt & d_fetch_miss,
						d_opt & d_call_tag,
						d_payload[15:0],
						d_kind,
						d_last,
						d_class,
						completion_code,
						3'b000};
					if (d_opt) begin
						format_three_len <= 6'd30;
					end else begin
						format_three_len <= 6'd28;
					end
				end else if (d_wide) begin
					// Standard form, three-bit code
					format_three_word <= {3'b000,
						d_opt & d_fetch_miss,
						d_opt & d_call_tag,
						d_payload[31:0],
						d_kind,
						d_last,
						d_class,
						completion_code[2:0],
						3'b000};
					if (d_opt) begin
						format_three_len <= 6'd45;
					end else begin
						format_three_len <= 6'd43;
					end
				end else begin
					format_three_word <= {19'h0_0000,
						d_opt & d_fetch_miss,
						d_opt & d_call_tag,
						d_payload[15:0],
						d_kind,
						d_last,
						d_class,
						completion_code[2:0],
						3'b000};
					if (d_opt) begin
						format_three_len <= 6'd29;
					end else begin
						format_three_len <= 6'd27;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/tce_collector.sv */
/*
 Far-side trace collector: takes each format three word.
 Assumes no back-pressure, so every valid cycle is one word.
*/
`timescale 1ns/1ps
`default_nettype none
module tce_collector (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic format_three_valid,
	input wire logic [5:0] format_three_len,
	input wire logic opt_bits_present,
	output var logic [31:0] f3_count,
	output var logic [5:0] payload_top
);
	// Count words; the presence flag says where the payload ends
	always @(posedge aclk) begin
		if (!aresetn) begin
			f3_count <= '0;
			payload_top <= '0;
		end else if (format_three_valid) begin
			f3_count <= f3_count + 32'h1;
			payload_top <= format_three_len - (opt_bits_present ? 6'h3 : 6'h1);
		end
	end
endmodule
`default_nettype wire

/* File: tb/tce_encoder_monitor.sv */
/*
 Checker on the encoder's word outputs.
 Assumes ce high and control writes spaced by a bus round trip.
*/
`timescale 1ns/1ps
`default_nettype none
module tce_encoder_monitor #(
	parameter PAYLOAD_MAX_W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic grad_valid,
	input wire logic grad_load,
	input wire logic grad_store,
	input wire logic grad_branch,
	input wire logic grad_unpredictable,
	input wire logic [3:0] stall_cause,
	input wire logic beat_valid,
	input wire logic format_two_valid,
	input wire logic [7:0] format_two_word,
	input wire logic [3:0] format_two_len,
	input wire logic format_three_valid,
	input wire logic [47:0] format_three_word,
	input wire logic opt_bits_present
);
	// Code field; odd lengths are the narrow standard form
	function automatic logic [3:0] f2c(input logic [7:0] w, input logic [3:0] n);
		f2c = n[0] ? {1'b0, w[4:2]} : w[5:2];
	endfunction
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Word two cycles after its cause; skipped while the length changes
	property p_code(c, logic [3:0] xc, logic [3:0] sc);
		c ##2 format_two_valid && format_two_len == $past(format_two_len, 2)
		|-> f2c(format_two_word, format_two_len) == (format_two_len[0] ? sc : xc);
	endproperty
	a_f2_marker: assert property (format_two_valid |-> format_two_word[1:0] == 2'b10)
		else $error("marker wrong");
	a_f2_length: assert property (format_two_valid |-> format_two_len inside {[5:8]})
		else $error("length wrong");
	a_no_reserved: assert property (format_two_valid |-> f2c(format_two_word, format_two_len) < 4'hC)
		else $error("reserved code");
	a_miss_code: assert property (p_code(!grad_valid && stall_cause == 4'h1, 4'h8, 4'h0))
		else $error("miss code");
	a_mispred_code: assert property (p_code(!grad_valid && stall_cause == 4'h2, 4'h9, 4'h0))
		else $error("mispredict code");
	a_replay_code: assert property (p_code(!grad_valid && stall_cause == 4'h4, 4'hA, 4'h0))
		else $error("replay code");
	a_backp_code: assert property (p_code(!grad_valid && stall_cause == 4'h8, 4'hB, 4'h0))
		else $error("backpressure code");
	a_load_code: assert property (p_code(grad_valid && grad_load && !grad_branch, 4'h2, 4'h2))
		else $error("load code");
	a_br_store: assert property (p_code(grad_valid && grad_branch && grad_unpredictable
		&& grad_store && !grad_load, 4'h7, 4'h7))
		else $error("branched store code");
	a_f3_pulse: assert property (beat_valid |-> ##2 format_three_valid)
		else $error("beat lost");
	a_f3_low_zero: assert property (format_three_valid |-> format_three_word[2:0] == 3'h0)
		else $error("low bits set");
	a_opt_absent: assert property (format_two_valid && !opt_bits_present
		|-> format_two_len <= 4'h6 && format_two_word[7:6] == 2'h0)
		else $error("optional bits leaked");
	c_wide_opt: cover property (format_three_valid && format_three_word[45]);
	c_opt_f2: cover property (opt_bits_present && format_two_len == 4'h8);
	c_backp: cover property (format_two_valid && f2c(format_two_word, format_two_len) == 4'hB);
endmodule
bind tce_encoder tce_encoder_monitor #(.PAYLOAD_MAX_W(PAYLOAD_MAX_W)) u_tce_encoder_monitor (
	.aclk, .aresetn, .grad_valid, .grad_load, .grad_store, .grad_branch, .grad_unpredictable,
	.stall_cause, .beat_valid, .format_two_valid, .format_two_word, .format_two_len,
	.format_three_valid, .format_three_word, .opt_bits_present);
`default_nettype wire

/* File: tb/tce_encoder_tb.sv */
/*
 Bench for the trace completion encoder: register sweep, random traffic.
 Assumes the checker is bound and the collector sits on the word side.
*/
`timescale 1ns/1ps
`default_nettype none
module tce_encoder_tb;
	logic aclk = 0, aresetn = 0, ce = 1;
	logic [7:0] s_awaddr = '0, s_araddr = '0;
	logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
	logic [31:0] s_wdata = '0, beat_payload = '0, r, f3_count;
	logic [3:0] s_wstrb = '0, stall_cause = '0, format_two_len;
	wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	wire [1:0] s_bresp, s_rresp;
	wire [31:0] s_rdata;
	logic grad_valid = 0, grad_load = 0, grad_store = 0, grad_branch = 0, grad_unpredictable = 0;
	logic grad_sync = 0, fetch_miss_flag = 0, call_tag = 0, beat_valid = 0;
	logic value_kind_flag = 0, last_beat_flag = 0, format_two_valid, format_three_valid;
	logic [2:0] packet_class = '0;
	logic [7:0] format_two_word;
	logic [47:0] format_three_word;
	logic [5:0] format_three_len, payload_top;
	logic opt_bits_present, go = 0, busy = 0, ext = 0, opt = 0, wide = 0;
	logic [66:0] e1 = '0, e2 = '0;
	integer seed = 55034;
	int cyc = 0, quiet = 0, fails = 0, samples_checked = 0, beats = 0, i;
	tce_encoder #(.PAYLOAD_MAX_W(32)) u_tce_encoder (.aclk, .aresetn, .ce, .s_awaddr, .s_awvalid,
		.s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
		.s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .grad_valid,
		.grad_load, .grad_store, .grad_branch, .grad_unpredictable, .grad_sync, .stall_cause,
		.fetch_miss_flag, .call_tag, .beat_valid, .beat_payload, .value_kind_flag,
		.last_beat_flag, .packet_class, .format_two_valid, .format_two_word, .format_two_len,
		.format_three_valid, .format_three_word, .format_three_len, .opt_bits_present);
	tce_collector u_tce_collector (.aclk, .aresetn, .format_three_valid, .format_three_len,
		.opt_bits_present, .f3_count, .payload_top);
	always #5 aclk = ~aclk;
	// Expected words of the inputs sampled at this edge
	function automatic logic [66:0] expect_now();
		logic [3:0] c, n2;
		logic [5:0] n3;
		logic [7:0] w2;
		logic [47:0] w3;
		if (grad_valid && grad_branch && grad_unpredictable)
			c = grad_load ? 4'h6 : grad_store ? 4'h7 : 4'h5;
		else if (grad_valid)
			c = grad_load ? 4'h2 : grad_store ? 4'h3 : grad_sync ? 4'h4 : 4'h1;
		else if (ext)
			c = stall_cause[0] ? 4'h8 : stall_cause[1] ? 4'h9 : stall_cause[2] ? 4'hA
				: stall_cause[3] ? 4'hB : 4'h0;
		else
			c = 4'h0;
		n2 = 4'h5 + ext + {opt, 1'b0};
		w2 = ext ? {2'h0, c, 2'b10} : {3'h0, c[2:0], 2'b10};
		n3 = (wide ? 6'h20 : 6'h10) + 6'hB + ext + {opt, 1'b0};
		w3 = {16'h0, wide ? beat_payload : {16'h0, beat_payload[15:0]}};
		w3 = ((w3 << 5 | {value_kind_flag, last_beat_flag, packet_class}) << (3 + ext) | c) << 3;
		if (opt) begin
			w2 = w2 | {fetch_miss_flag, call_tag} << (n2 - 2);
			w3 = w3 | {fetch_miss_flag, call_tag} << (n3 - 2);
		end
		return {beat_valid, n3, w3, n2, w2};
	endfunction
	task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
		samples_checked++;
		if (exp !== got) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 0;
		w = 0;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= 4'hF;
		s_awvalid <= 1;
		s_wvalid <= 1;
		s_bready <= 1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && s_awready) begin
				aw = 1;
				s_awvalid <= 0;
			end
			if (!w && s_wready) begin
				w = 1;
				s_wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!s_bvalid);
		s_bready <= 0;
		check("write response", er, s_bresp);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, ed, input logic [1:0] er);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1;
		s_rready <= 1;
		do @(posedge aclk); while (!s_arready);
		s_arvalid <= 0;
		do @(posedge aclk); while (!s_rvalid);
		s_rready <= 0;
		check("read data", ed, s_rdata & m);
		check("read response", er, s_rresp);
	endtask
	// Idle word gets the opposite bits, so a wrong owner shows at once
	task automatic cfg(input logic [3:0] k);
		logic [31:0] act;
		busy = 1;
		{ext, opt, wide} = k[2:0];
		act = {3'h0, ext, 27'h0, opt};
		wr(8'h00, k[3] ? act ^ 32'h1000_0001 : act, 2'h0);
		wr(8'h04, (k[3] ? act : act ^ 32'h1000_0001) | {8'h0, wide, 23'h0}, 2'h0);
		wr(8'h08, {31'h0, k[3]}, 2'h0);
		rd(8'h0C, 32'h0000_0007, {29'h0, opt, wide, ext}, 2'h0);
		busy = 0;
	endtask
	// Pipeline the expectations and draw fresh traffic; checks wait out config changes
	always @(posedge aclk) begin
		e1 <= aresetn ? expect_now() : '0;
		e2 <= aresetn ? e1 : '0;
		quiet <= (busy || !aresetn) ? 0 : quiet + 1;
		cyc <= cyc + 1;
		if (go) begin
			r = $random(seed);
			{packet_class, last_beat_flag, value_kind_flag, beat_valid, call_tag} <= r[17:11];
			{fetch_miss_flag, stall_cause, grad_sync, grad_unpredictable} <= r[10:4];
			{grad_branch, grad_store, grad_load, grad_valid} <= {r[3], r[2] & ~r[1], r[1:0]};
			beat_payload <= $random(seed);
		end else begin
			// Stop the beat stream so the final counts can settle
			beat_valid <= 1'b0;
		end
		if (cyc == 30000) begin
			fails++;
			final_report();
		end
	end
	// Outputs are settled at the falling edge
	always @(negedge aclk) begin
		if (aresetn && e2[66])
			beats++;
		if (quiet >= 4) begin
			check("format_two_word", e2[7:0], format_two_word);
			check("format_two_len", e2[11:8], format_two_len);
			check("format_two_valid", 1, format_two_valid);
			check("opt_bits_present", opt, opt_bits_present);
			check("format_three_valid", e2[66], format_three_valid);
			if (e2[66]) begin
				check("format_three_word", e2[59:12], format_three_word);
				check("format_three_len", e2[65:60], format_three_len);
			end
		end
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		rd(8'h00, 32'hFFFF_FFFF, 32'h0, 2'h0);
		rd(8'h04, 32'hFFFF_FFFF, 32'h0, 2'h0);
		rd(8'h08, 32'h0000_0001, 32'h0, 2'h0);
		rd(8'h20, 32'hFFFF_FFFF, 32'h0, 2'h2);
		wr(8'h24, 32'hFFFF_FFFF, 2'h2);
		wr(8'h0C, 32'hFFFF_FFFF, 2'h0);
		go <= 1;
		for (i = 0; i < 16; i++) begin
			cfg(i[3:0]);
			repeat (200) @(posedge aclk);
		end
		go <= 0;
		repeat (4) @(posedge aclk);
		check("format three count", beats, f3_count);
		check("payload top", (wide ? 6'd42 : 6'd26) + ext, payload_top);
		rd(8'h18, 32'hFFFF_FFFF, beats, 2'h0);
		final_report();
	end
endmodule
`default_nettype wire
